// ---- hdl/pdg_duty_path.sv ----
/*
  Duty double-buffer and output latch for the PWM generator.
  Assumes the time base supplies an extended count and period-end strobe.
*/
`timescale 1ns/1ps
module pdg_duty_path
(
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Control
  input  wire logic               pwm_mode,
  input  wire logic               force_low,
  input  wire logic [9:0]         duty_value,
  input  wire logic               shadow_wr,
  input  wire logic [7:0]         shadow_wdata,
  input  wire pdg_pkg::pdg_tbase_t tbase,
  // Results
  output      logic [7:0]         duty_shadow_high,
  output      logic               pwm_level
);

  logic [1:0] shadow_low;                                 // Hidden 2-bit latch
  logic       duty_zero;
  logic       hit;
  logic       period_end_q;

  // Zero test on the buffered duty, which is the value this period uses
  assign duty_zero = ({duty_shadow_high, shadow_low} == 10'h000);
  // Equality only: a duty past the period never matches
  assign hit = ({duty_shadow_high, shadow_low} == tbase.ext_count);

  // Shadow loads from duty at period end in PWM mode; bus writes load the high byte only outside PWM mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      duty_shadow_high <= pdg_pkg::RST_DUTY;
      shadow_low       <= 2'h0;
    end
    else if (pwm_mode && tbase.period_end)
    begin
      duty_shadow_high <= duty_value[9:2];
      shadow_low       <= duty_value[1:0];
    end
    else if (shadow_wr && !pwm_mode)
      duty_shadow_high <= shadow_wdata;
  end

  // Period end delayed one cycle; the match clear is registered too, so the
  // set must lag by the same cycle or every pulse runs one cycle long
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      period_end_q <= 1'b0;
    else
      period_end_q <= pwm_mode && tbase.period_end;
  end

  // Output latch: set after period end, cleared on the duty match
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwm_level <= 1'b0;
    else if (force_low || !pwm_mode)
      pwm_level <= 1'b0;
    else if (period_end_q)
      pwm_level <= !duty_zero;
    else if (hit)
      pwm_level <= 1'b0;
  end

endmodule

// ---- hdl/pdg_pkg.sv ----
/*
  Package for the PWM duty-cycle generator: register offsets, field
  positions, reset values, mode codes and bus carrier types.
  Assumes an APB slave with 32-bit data; offsets are register indices.
*/
package pdg_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_TIMER_COUNT   = 8'h11;
  localparam logic [7:0] IDX_TIMER_CONTROL = 8'h12;
  localparam logic [7:0] IDX_DUTY_HIGH     = 8'h15;
  localparam logic [7:0] IDX_DUTY_SHADOW   = 8'h16;
  localparam logic [7:0] IDX_MODE_CONTROL  = 8'h17;
  localparam logic [7:0] IDX_PERIOD        = 8'h92;

  // Reset values
  localparam logic [7:0] RST_TIMER_COUNT   = 8'h00;
  localparam logic [6:0] RST_TIMER_CONTROL = 7'h00;
  localparam logic [7:0] RST_DUTY          = 8'h00;
  localparam logic [5:0] RST_MODE_CONTROL  = 6'h00;
  localparam logic [7:0] RST_PERIOD        = 8'hFF;

  // Field positions in the timer control register
  localparam int TCON_RUN_BIT    = 2;
  localparam int TCON_PS_LSB     = 0;
  localparam int TCON_POST_LSB   = 3;

  // Field positions in the mode control register
  localparam int MCON_LOW_LSB    = 4;
  localparam int MCON_MODE_LSB   = 0;

  // Mode select: PWM when the top two mode bits are both set
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;

  // Prescale selects
  localparam logic [1:0] PS_DIV1  = 2'h0;
  localparam logic [1:0] PS_DIV4  = 2'h1;

  // Phase counter: four oscillator cycles per timer instruction cycle
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [3:0] PRE_LAST4  = 4'h3;
  localparam logic [3:0] PRE_LAST16 = 4'hF;

  // APB request carrier
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } pdg_apb_req_t;

  // Time-base carrier: count with fraction and period-end strobe
  typedef struct packed {
    logic [9:0] ext_count;
    logic       period_end;
    logic       tick;
  } pdg_tbase_t;

endpackage

// ---- hdl/pdg_pwm_top.sv ----
/*
  PWM duty-cycle generator top: APB register slave, period time base and
  duty double-buffer with output latch.
  Assumes pclk is the oscillator; the pin direction latch lives outside
  and software clears it before using the pin.
*/
`timescale 1ns/1ps

// How it works
// - Duty is high byte register as top eight bits, mode bits 5:4 below.
// - High time equals duty times oscillator period times prescale factor.
// - Duty writes accepted anytime, copied to shadow only at period match.
// - In PWM mode the shadow high register is read-only.
// - Shadow high plus hidden 2-bit latch double-buffer the duty.
// - Output clears when shadow duty equals timer count plus two phase bits at divide-by-1, else two prescaler bits.
// - Duty longer than period never clears the output.
// - Prescaler divides by 1, 4 or 16.
// - After period match: timer clears, output sets unless zero, shadow loads.
// - Writing zero to mode control forces the output latch low.
// - Postscaler has no effect on PWM period or frequency.
module pdg_pwm_top
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // PWM pin
  output      logic        pwm_output_pin
);

  ////////////////////////////////////////////////////////////////////
  // Bus decode

  pdg_pkg::pdg_apb_req_t req;
  logic       access;
  logic       wr_en;
  logic [7:0] reg_idx;
  logic       addr_ok;
  logic       hit_count;
  logic       hit_tcon;
  logic       hit_duty;
  logic       hit_shadow;
  logic       hit_mode;
  logic       hit_period;

  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
  // Index is the byte address over four; misaligned words are unmapped
  assign reg_idx    = req.addr[9:2];
  assign addr_ok    = (req.addr[1:0] == 2'h0) && (req.addr[11:10] == 2'h0);
  assign hit_count  = addr_ok && (reg_idx == pdg_pkg::IDX_TIMER_COUNT);
  assign hit_tcon   = addr_ok && (reg_idx == pdg_pkg::IDX_TIMER_CONTROL);
  assign hit_duty   = addr_ok && (reg_idx == pdg_pkg::IDX_DUTY_HIGH);
  assign hit_shadow = addr_ok && (reg_idx == pdg_pkg::IDX_DUTY_SHADOW);
  assign hit_mode   = addr_ok && (reg_idx == pdg_pkg::IDX_MODE_CONTROL);
  assign hit_period = addr_ok && (reg_idx == pdg_pkg::IDX_PERIOD);
  // Zero-wait slave: the access phase completes in its first cycle
  assign access = req.sel && req.enable;
  assign wr_en  = access && req.write;

  ////////////////////////////////////////////////////////////////////
  // Software registers

  logic [6:0] period_timer_control;
  logic [7:0] duty_high_byte;
  logic [5:0] unit_mode_control;
  logic [7:0] period_compare_value;

  // Control registers take the write in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      period_timer_control <= pdg_pkg::RST_TIMER_CONTROL;
      duty_high_byte       <= pdg_pkg::RST_DUTY;
      unit_mode_control    <= pdg_pkg::RST_MODE_CONTROL;
      period_compare_value <= pdg_pkg::RST_PERIOD;
    end
    else if (wr_en)
    begin
      if (hit_tcon)
        period_timer_control <= req.wdata[6:0];
      if (hit_duty)
        duty_high_byte <= req.wdata[7:0];
      if (hit_mode)
        unit_mode_control <= req.wdata[5:0];
      if (hit_period)
        period_compare_value <= req.wdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Field extraction

  logic       period_timer_run;
  logic [1:0] prescale_select;
  logic [3:0] postscale_select;
  logic       pwm_mode;
  logic [9:0] duty_value;
  logic       mode_clear;

  assign period_timer_run = period_timer_control[pdg_pkg::TCON_RUN_BIT];
  assign prescale_select  = period_timer_control[pdg_pkg::TCON_PS_LSB +: 2];
  // Postscale is stored and read back only; it never reaches the time base
  assign postscale_select = period_timer_control[pdg_pkg::TCON_POST_LSB +: 4];
  assign pwm_mode   = (unit_mode_control[pdg_pkg::MCON_MODE_LSB + 2 +: 2]
                       == pdg_pkg::MODE_PWM_TOP);
  assign duty_value = {duty_high_byte,
                       unit_mode_control[pdg_pkg::MCON_LOW_LSB +: 2]};
  assign mode_clear = wr_en && hit_mode && (req.wdata[5:0] == 6'h00);

  ////////////////////////////////////////////////////////////////////
  // Time base and duty path

  pdg_pkg::pdg_tbase_t tbase;
  logic [7:0] period_timer_count;
  logic [7:0] duty_shadow_high;
  logic       pwm_level;

  // High time = duty * oscillator period * prescale factor
  pdg_timebase u_timebase
  (
    .pclk         (pclk),
    .presetn      (presetn),
    .run          (period_timer_run),
    .prescale_sel (prescale_select),
    .period_value (period_compare_value),
    .count_wr     (wr_en && hit_count),
    .ctrl_wr      (wr_en && hit_tcon),
    .count_wdata  (req.wdata[7:0]),
    .count        (period_timer_count),
    .tbase        (tbase)
  );

  pdg_duty_path u_duty
  (
    .pclk             (pclk),
    .presetn          (presetn),
    .pwm_mode         (pwm_mode),
    .force_low        (mode_clear),
    .duty_value       (duty_value),
    .shadow_wr        (wr_en && hit_shadow),
    .shadow_wdata     (req.wdata[7:0]),
    .tbase            (tbase),
    .duty_shadow_high (duty_shadow_high),
    .pwm_level        (pwm_level)
  );

  ////////////////////////////////////////////////////////////////////
  // Read mux and outputs

  logic [31:0] next_prdata;

  assign next_prdata =
    hit_count  ? {24'h000000, period_timer_count} :
    hit_tcon   ? {25'h0000000, postscale_select, period_timer_run, prescale_select} :
    hit_duty   ? {24'h000000, duty_high_byte} :
    hit_shadow ? {24'h000000, duty_shadow_high} :
    hit_mode   ? {26'h0000000, unit_mode_control} :
    hit_period ? {24'h000000, period_compare_value} : 32'h00000000;

  // Registered answer in the access cycle; unmapped gives pslverr
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata  <= (req.sel && !req.enable && !req.write) ? next_prdata : prdata;
      pready  <= req.sel && !req.enable;
      pslverr <= req.sel && !req.enable && !(hit_count || hit_tcon || hit_duty ||
                 hit_shadow || hit_mode || hit_period);
    end
  end

  // Pin follows the output latch through one flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwm_output_pin <= 1'b0;
    else
      pwm_output_pin <= pwm_level;
  end

endmodule

// ---- hdl/pdg_timebase.sv ----
/*
  Period timer with prescaler for the PWM generator.
  Assumes one clock; the oscillator is pclk, the timer counts once per
  four oscillator cycles times the prescale factor.
*/
`timescale 1ns/1ps
module pdg_timebase
(
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Control
  input  wire logic               run,
  input  wire logic [1:0]         prescale_sel,
  input  wire logic [7:0]         period_value,
  input  wire logic               count_wr,
  input  wire logic               ctrl_wr,
  input  wire logic [7:0]         count_wdata,
  // Status
  output      logic [7:0]         count,
  output      pdg_pkg::pdg_tbase_t tbase
);

  logic [3:0] pre;
  logic [1:0] phase;
  logic [3:0] pre_last;
  logic       step;
  logic       at_period;
  logic [1:0] frac;

  // Divide factors 1, 4 and 16 (both upper codes give 16)
  assign pre_last = (prescale_sel == pdg_pkg::PS_DIV1) ? 4'h0 :
                    (prescale_sel == pdg_pkg::PS_DIV4) ? pdg_pkg::PRE_LAST4 :
                    pdg_pkg::PRE_LAST16;
  assign step      = run && (phase == pdg_pkg::PHASE_LAST) && (pre == pre_last);
  assign at_period = (count == period_value);
  // Fraction: phase for divide-by-1, else two prescaler bits
  assign frac = (prescale_sel == pdg_pkg::PS_DIV1) ? phase :
                (prescale_sel == pdg_pkg::PS_DIV4) ? pre[1:0] : pre[3:2];

  assign tbase.ext_count  = {count, frac};
  assign tbase.period_end = step && at_period;
  assign tbase.tick       = step;

  // Phase and prescaler run while the timer is enabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase <= 2'h0;
      pre   <= 4'h0;
    end
    else if (count_wr || ctrl_wr)
    begin
      phase <= 2'h0;                                      // Writes restart the divider
      pre   <= 4'h0;
    end
    else if (run)
    begin
      phase <= phase + 2'h1;
      if (phase == pdg_pkg::PHASE_LAST)
        pre <= (pre == pre_last) ? 4'h0 : pre + 4'h1;
    end
  end

  // Timer count clears on the increment after a period match
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= pdg_pkg::RST_TIMER_COUNT;
    else if (count_wr)
      count <= count_wdata;
    else if (step)
      count <= at_period ? 8'h00 : count + 8'h01;
  end

endmodule

// ---- tb/pdg_pwm_props.sv ----
/*
  Checker for the PWM generator top ports.
  Assumes a bind onto pdg_pwm_top and a zero-wait APB slave.
*/
`timescale 1ns/1ps
module pdg_pwm_props
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pin
  input wire logic        pwm_output_pin
);
  logic [5:0] mode_q;
  logic [7:0] duty_q;
  wire        acc    = psel && penable;
  wire        wr_ok  = acc && pready && pwrite;
  wire        hit    = paddr inside {12'h044, 12'h048, 12'h054, 12'h058, 12'h05C, 12'h248};
  wire        pwm_on = mode_q[3:2] == 2'h3;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  // Mirror of what software wrote, so readback is judged against intent
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q <= 6'h00;
      duty_q <= 8'h00;
    end
    else
    begin
      if (wr_ok && paddr == 12'h05C)
        mode_q <= pwdata[5:0];
      if (wr_ok && paddr == 12'h054)
        duty_q <= pwdata[7:0];
    end
  end
  ////////////////////////////////////////////////////////////////
  // Bus, readback and pin relations
  chk_ready_access: assert property (acc |-> pready)
    else $error("pready missing in access");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_unmapped: assert property (acc && !hit |-> pslverr)
    else $error("unmapped access not refused");
  chk_no_err_mapped: assert property (acc && hit |-> !pslverr)
    else $error("mapped access refused");
  chk_duty_readback: assert property (acc && !pwrite && paddr == 12'h054 |-> prdata == {24'h0, duty_q})
    else $error("duty byte readback wrong");
  chk_mode_readback: assert property (acc && !pwrite && paddr == 12'h05C |-> prdata == {26'h0, mode_q})
    else $error("mode readback wrong");
  chk_zero_forces: assert property (wr_ok && paddr == 12'h05C && pwdata == 32'h0 |-> ##[1:4] !pwm_output_pin)
    else $error("pin not forced low");
  chk_rise_in_mode: assert property ($rose(pwm_output_pin) |-> $past(pwm_on, 2))
    else $error("pin rose outside pwm mode");
  chk_low_outside: assert property (!pwm_on && !$past(pwm_on) && !$past(pwm_on, 2) |-> !pwm_output_pin)
    else $error("pin high outside pwm mode");
  cover property ($rose(pwm_output_pin));
  cover property (acc && pslverr);
  cover property (wr_ok && paddr == 12'h05C && pwdata == 32'h0);
endmodule

// ---- tb/pdg_pwm_top_tb.sv ----
/*
  Self-checking bench for the PWM generator top.
  Assumes a zero-wait APB slave and a 100 MHz clock.
*/
`timescale 1ns/1ps
module pdg_pwm_top_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pin, pin_d, err_s;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  int          fails, check_count, cyc, rise_n, fall_n, hi_cnt, per_cnt, hi_len, per_len, k;

  pdg_pwm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_output_pin(pin));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////
  // Pulse monitor and hang guard; lengths count pclk cycles
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    pin_d <= pin;
    hi_cnt <= pin ? hi_cnt + 1 : 0;
    per_cnt <= (pin && !pin_d) ? 1 : per_cnt + 1;
    if (pin && !pin_d)
    begin
      rise_n <= rise_n + 1;
      per_len <= per_cnt;
    end
    if (!pin && pin_d)
    begin
      fall_n <= fall_n + 1;
      hi_len <= hi_cnt;
    end
    if (cyc == 20000)
    begin
      fails++;
      stop_test;
    end
  end
  ////////////////////////////////////////////////////////////////
  task stop_test;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  // One APB transfer; request held until pready is sampled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    err_s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("rd %h", a), e, rdv);
  endtask

  task wait_rises(input int n);
    int t;
    t = rise_n + n;
    while (rise_n < t)
      @(posedge pclk);
  endtask

  task cfg(input logic [7:0] per, input logic [9:0] d, input logic [6:0] tc);
    apb(1'b1, 12'h248, {24'h0, per});
    apb(1'b1, 12'h054, {24'h0, d[9:2]});
    apb(1'b1, 12'h05C, {26'h0, d[1:0], 4'h0});
    apb(1'b1, 12'h048, {25'h0, tc});
    apb(1'b1, 12'h05C, {26'h0, d[1:0], 4'hC});
  endtask
  ////////////////////////////////////////////////////////////////
  task t_reset;
    logic [11:0] ra [6];
    logic [31:0] rv [6];
    ra = '{12'h044, 12'h048, 12'h054, 12'h058, 12'h05C, 12'h248};
    rv = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hFF};
    for (int i = 0; i < 6; i++)
      rd(ra[i], rv[i]);
    apb(1'b1, 12'h058, 32'h3C);
    rd(12'h058, 32'h3C);
    apb(1'b0, 12'h100, 32'h0);
    chk("slverr", 32'h1, {31'h0, err_s});
    $display("test reset done");
  endtask

  // Duty 5 with low bits 01, three prescales, postscale set on the last
  task t_period;
    logic [6:0] tc [3];
    int         ps [3];
    tc = '{7'h04, 7'h05, 7'h7E};
    ps = '{1, 4, 16};
    for (int i = 0; i < 3; i++)
    begin
      cfg(8'h03, 10'h005, tc[i]);
      wait_rises(3);
      chk("high", 32'(5 * ps[i]), 32'(hi_len));
      chk("period", 32'(16 * ps[i]), 32'(per_len));
    end
    $display("test period done");
  endtask

  // Duty cut from 20 to 8 while the pin is high
  task t_buffer;
    cfg(8'h07, 10'd20, 7'h04);
    wait_rises(3);
    apb(1'b1, 12'h054, 32'h02);
    wait_rises(1);
    chk("high old", 32'd20, 32'(hi_len));
    wait_rises(1);
    chk("high new", 32'd8, 32'(hi_len));
    apb(1'b1, 12'h058, 32'hAA);
    rd(12'h058, 32'h02);
    $display("test buffer done");
  endtask

  task t_edges;
    apb(1'b1, 12'h054, 32'h20);
    repeat (64) @(posedge pclk);
    k = fall_n;
    repeat (64) @(posedge pclk);
    chk("no fall", 32'(k), 32'(fall_n));
    chk("pin high", 32'h1, {31'h0, pin});
    apb(1'b1, 12'h054, 32'h00);
    repeat (64) @(posedge pclk);
    k = rise_n;
    repeat (64) @(posedge pclk);
    chk("no rise", 32'(k), 32'(rise_n));
    chk("pin low", 32'h0, {31'h0, pin});
    $display("test edges done");
  endtask

  task t_clear;
    apb(1'b1, 12'h054, 32'h05);
    wait_rises(2);
    apb(1'b1, 12'h05C, 32'h0);
    repeat (4) @(posedge pclk);
    chk("pin off", 32'h0, {31'h0, pin});
    k = rise_n;
    repeat (64) @(posedge pclk);
    chk("stay off", 32'(k), 32'(rise_n));
    rd(12'h05C, 32'h0);
    $display("test clear done");
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pin_d = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_period;
    t_buffer;
    t_edges;
    t_clear;
    stop_test;
  end
endmodule

bind pdg_pwm_top pdg_pwm_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pwm_output_pin(pwm_output_pin));
